//--- rtl/host_port_consts.svh
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

// ============================================================
// Pin level encodings
`define HP_WIDTH_16      1'b0
`define HP_WIDTH_8       1'b1
`define HP_STYLE_SPLIT   1'b0
`define HP_STYLE_DIRSTB  1'b1

// ============================================================
// Bus geometry
`define HP_DATA_W        16
`define HP_ADDR_W        8
`define HP_IRQ_SRC_W     8
`define HP_BYTE_W        8

// ============================================================
// Reset values
`define HP_ADDR_RST      8'h00
`define HP_DATA_RST      16'h0000

`endif

//--- rtl/host_port_pkg.sv
package host_port_pkg;
  // Access decoded from the strobe pins
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } access_e;
endpackage

//--- rtl/host_port_if.sv
`timescale 1ns/1ps
// ============================================================
// Internal register access carrier
interface host_port_if #(
  parameter int AW = 8,
  parameter int DW = 16
);
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          wr_pulse;
  logic          rd_active;
  logic [DW-1:0] rdata;
  modport front (output addr, output wdata, output wr_pulse, output rd_active, input rdata);
  modport regs  (input addr, input wdata, input wr_pulse, input rd_active, output rdata);
endinterface

//--- rtl/host_pin_sync.sv
`timescale 1ns/1ps
// ============================================================
// Two-flop synchroniser for a bus of pin inputs
module host_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk_sys, // System clock
  input  wire logic         i_rst_b,   // Async reset, active low
  input  wire logic [W-1:0] i_async,   // Pin levels
  output logic      [W-1:0] o_sync     // Synchronised levels
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

//--- rtl/host_cpu_bus_port.sv
`timescale 1ns/1ps
`include "host_port_consts.svh"
module host_cpu_bus_port #(
  parameter int DW = `HP_DATA_W,
  parameter int AW = `HP_ADDR_W,
  parameter int NS = `HP_IRQ_SRC_W
) (
  input  wire logic          i_clk_sys,             // System clock
  input  wire logic          i_rst_b,               // Async reset, active low
  input  wire logic          i_bus_width_select,    // 0 16-bit, 1 8-bit
  input  wire logic          i_bus_style_select,    // 0 split, 1 dir+strobe
  input  wire logic [DW-1:0] i_host_data_lines,     // Data pins in
  output logic      [DW-1:0] o_host_data_lines,     // Data pins out
  output logic               o_host_data_oe,        // Data pins driven
  input  wire logic [AW-1:0] i_host_address_lines,  // Address pins
  input  wire logic          i_host_write_strobe_n, // Write strobe / dir select
  input  wire logic          i_host_read_strobe_n,  // Read strobe / data strobe
  input  wire logic          i_host_select_n,       // Chip select
  input  wire logic          i_host_addr_latch_en,  // Address latch enable
  input  wire logic [NS-1:0] i_irq_src,             // Interrupt source levels
  input  wire logic [NS-1:0] i_irq_mask,            // Interrupt mask, 1 masks
  output logic               o_host_irq_n_oe,       // Irq pin pulled low
  input  wire logic [DW-1:0] i_reg_rdata,           // Register file read data
  output logic      [AW-1:0] o_reg_addr,            // Register address
  output logic      [DW-1:0] o_reg_wdata,           // Register write data
  output logic               o_reg_wr,              // Write pulse
  output logic               o_reg_rd               // Read in progress
);

  // ============================================================
  // Pin synchronisation
  localparam int SW = DW + AW + 6;
  logic [SW-1:0] pins_sync;
  logic [DW-1:0] s_data;
  logic [AW-1:0] s_addr;
  logic          s_width;
  logic          s_style;
  logic          s_wr_n;
  logic          s_rd_n;
  logic          s_cs_n;
  logic          s_ale;
  logic          s_wr_act;
  logic          s_rd_act;
  logic          s_cs_act;

  host_pin_sync #(.W(SW)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_async   ({i_host_data_lines, i_host_address_lines, i_bus_width_select,
                 i_bus_style_select, !i_host_write_strobe_n, !i_host_read_strobe_n,
                 !i_host_select_n, i_host_addr_latch_en}),
    .o_sync    (pins_sync)
  );

  // Strobes cross active high, so a synchroniser in reset reads as idle
  assign {s_data, s_addr, s_width, s_style, s_wr_act, s_rd_act, s_cs_act, s_ale} = pins_sync;
  assign s_wr_n = !s_wr_act;
  assign s_rd_n = !s_rd_act;
  assign s_cs_n = !s_cs_act;

  host_port_if #(.AW(AW), .DW(DW)) acc ();

  // ============================================================
  // Address latch
  logic [AW-1:0] addr_hold;

  // Hold the address while the enable is low
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_hold <= `HP_ADDR_RST;
    end else if (s_ale) begin
      addr_hold <= s_addr;
    end
  end

  // Transparent while high, held value otherwise
  wire [AW-1:0] addr_eff  = s_ale ? s_addr : addr_hold;
  wire          width_8   = (s_width == `HP_WIDTH_8);
  wire [AW-1:0] addr_dec  = width_8 ? addr_eff : {addr_eff[AW-1:1], 1'b0};

  // ============================================================
  // Access decode
  wire style_dir = (s_style == `HP_STYLE_DIRSTB);
  wire selected  = !s_cs_n;
  wire split_rd  = selected && !style_dir && !s_rd_n;
  wire split_wr  = selected && !style_dir && !s_wr_n;
  wire dir_rd    = selected && style_dir && !s_rd_n && s_wr_n;
  wire dir_wr    = selected && style_dir && !s_rd_n && !s_wr_n;

  host_port_pkg::access_e access;
  assign access = (split_rd || dir_rd) ? host_port_pkg::ACC_READ :
                  (split_wr || dir_wr) ? host_port_pkg::ACC_WRITE :
                  host_port_pkg::ACC_IDLE;

  // ============================================================
  // Byte lane narrowing
  // Keep the low byte and clear the rest, for 8-bit width
  function automatic logic [DW-1:0] low_byte_only(input logic [DW-1:0] word);
    low_byte_only = {{(DW-`HP_BYTE_W){1'b0}}, word[`HP_BYTE_W-1:0]};
  endfunction

  // ============================================================
  // Write event tracking
  logic wr_prev;
  logic wr_dir_prev;
  logic [DW-1:0] wdata_prev;

  // Remember previous strobe and data for edge detection
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_prev     <= 1'b0;
      wr_dir_prev <= 1'b0;
      wdata_prev  <= `HP_DATA_RST;
    end else begin
      wr_prev     <= split_wr;
      wr_dir_prev <= dir_wr;
      wdata_prev  <= s_data;
    end
  end

  // Split style writes on strobe release; dir style on data strobe rise
  wire wr_split_end = wr_prev && !split_wr;
  wire wr_dir_end   = wr_dir_prev && s_rd_n;
  wire [DW-1:0] wdata_eff = width_8 ? low_byte_only(wdata_prev) : wdata_prev;

  assign acc.addr      = addr_dec;
  assign acc.wdata     = wdata_eff;
  assign acc.wr_pulse  = wr_split_end || wr_dir_end;
  assign acc.rd_active = (access == host_port_pkg::ACC_READ);
  assign acc.rdata     = i_reg_rdata;

  // ============================================================
  // Register side outputs
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_addr  <= `HP_ADDR_RST;
      o_reg_wdata <= `HP_DATA_RST;
      o_reg_wr    <= 1'b0;
      o_reg_rd    <= 1'b0;
    end else begin
      o_reg_addr  <= acc.addr;
      o_reg_wdata <= acc.wdata;
      o_reg_wr    <= acc.wr_pulse;
      o_reg_rd    <= acc.rd_active;
    end
  end

  // ============================================================
  // Read data drive
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_host_data_lines <= `HP_DATA_RST;
      o_host_data_oe    <= 1'b0;
    end else begin
      o_host_data_oe    <= acc.rd_active;
      o_host_data_lines <= width_8 ? low_byte_only(acc.rdata) : acc.rdata;
    end
  end

  // ============================================================
  // Interrupt output
  logic [NS-1:0] irq_live;

  // One gate per source: active and not masked
  for (genvar g = 0; g < NS; g++) begin : g_irq
    assign irq_live[g] = i_irq_src[g] && !i_irq_mask[g];
  end

  // Pin pulled low while any gated source stands
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_host_irq_n_oe <= 1'b0;
    end else begin
      o_host_irq_n_oe <= |irq_live;
    end
  end

endmodule

//--- tb/host_cpu_bus_port_asserts.sv
`timescale 1ns/1ps
// ==========
// Pin checks of the host port
module host_cpu_bus_port_asserts (
  input wire logic        i_clk_sys,             // Clock
  input wire logic        i_rst_b,               // Reset
  input wire logic        i_bus_width_select,    // Width
  input wire logic        i_bus_style_select,    // Style
  input wire logic        i_host_write_strobe_n, // Dir
  input wire logic        i_host_read_strobe_n,  // Strobe
  input wire logic        i_host_select_n,       // Select
  input wire logic [7:0]  i_irq_src,             // Sources
  input wire logic [7:0]  i_irq_mask,            // Masks
  input wire logic        o_host_irq_n_oe,       // Irq
  input wire logic        o_host_data_oe,        // Drive
  input wire logic [7:0]  o_reg_addr,            // Address
  input wire logic [15:0] o_reg_wdata,           // Data
  input wire logic        o_reg_wr               // Write
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // Pin level wanted from the sources and masks
  logic irq_want;
  assign irq_want = |(i_irq_src & ~i_irq_mask);
  // Read request in either style
  sequence s_rd_req;
    !i_host_select_n && !i_host_read_strobe_n && (i_host_write_strobe_n || !i_bus_style_select);
  endsequence
  // Relations at the pins
  a_read_drives: assert property (s_rd_req [*5] |-> o_host_data_oe)
    else $error("read not driven");
  a_idle_quiet: assert property (i_host_select_n [*4] |-> !o_host_data_oe)
    else $error("driven unselected");
  a_unsel_no_wr: assert property (i_host_select_n [*8] |-> !o_reg_wr)
    else $error("write unselected");
  a_wr_one_cycle: assert property (o_reg_wr |=> !o_reg_wr)
    else $error("long write");
  a_wr_no_drive: assert property (o_reg_wr |-> !o_host_data_oe)
    else $error("write while driving");
  a_addr16_even: assert property (o_reg_wr && !i_bus_width_select |-> !o_reg_addr[0])
    else $error("odd wide address");
  a_upper8_zero: assert property (o_reg_wr && i_bus_width_select |-> o_reg_wdata[15:8] == 8'h00)
    else $error("upper byte written");
  a_irq_level: assert property ($past(i_rst_b, 2) |-> o_host_irq_n_oe == $past(irq_want))
    else $error("irq level wrong");
endmodule
bind host_cpu_bus_port host_cpu_bus_port_asserts i_chk (.i_clk_sys, .i_rst_b, .i_bus_width_select,
  .i_bus_style_select, .i_host_write_strobe_n, .i_host_read_strobe_n, .i_host_select_n, .i_irq_src,
  .i_irq_mask, .o_host_irq_n_oe, .o_host_data_oe, .o_reg_addr, .o_reg_wdata, .o_reg_wr);

//--- tb/host_bus_model.sv
`timescale 1ns/1ps
// ==========
// Host processor model
module host_bus_model (
  input  wire logic        i_clk_sys, // Clock
  input  wire logic        i_style,   // Style
  output logic             o_sel_n,   // Select
  output logic             o_wr_n,    // Write or dir
  output logic             o_rd_n,    // Read or strobe
  output logic             o_ale,     // Latch enable
  output logic [7:0]       o_addr,    // Address
  output logic [15:0]      o_data     // Data
);
  initial {o_sel_n, o_wr_n, o_rd_n, o_ale, o_addr, o_data} = 28'hf00_0000;
  // One access; select high makes it a refused one
  task automatic access(input logic rd, cs, mux, input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk_sys) #1;
    o_addr = a;
    o_data = rd ? o_data : (mux ? {8'h00, a} : d);
    if (mux) begin
      repeat (4) @(posedge i_clk_sys) #1;
      o_ale = 1'b0;
      repeat (4) @(posedge i_clk_sys) #1;
      o_data = d;
      o_addr = d[7:0];
    end
    o_sel_n = cs;
    o_wr_n  = rd;
    o_rd_n  = i_style ? 1'b0 : !rd;
    repeat (6) @(posedge i_clk_sys) #1;
    o_rd_n = 1'b1;
    o_wr_n = o_wr_n | !i_style;
    repeat (2) @(posedge i_clk_sys) #1;
    {o_sel_n, o_wr_n, o_ale} = 3'h7;
    o_data = ~o_data;
    repeat (4) @(posedge i_clk_sys);
  endtask
endmodule

//--- tb/host_cpu_bus_port_tb.sv
`timescale 1ns/1ps
// ==========
// Bench of the host port
module host_cpu_bus_port_tb;
  logic        clk_sys = 1'b0, rst_b = 1'b0, width = 1'b0, style = 1'b0, irq_on = 1'b0, irq_exp = 1'b0;
  logic        oe_d = 1'b0, sel_n, wr_n, rd_n, ale, data_oe, irq_oe, reg_wr, reg_rd, rd_flag = 1'b0;
  logic [7:0]  irq_src = 8'h00, irq_mask = 8'h00, addr, reg_addr;
  logic [15:0] host_data, dut_data, reg_wdata, rd_seen, data_in;
  logic [23:0] exp_q[$];
  int          n_errors = 0, cmp_count = 0;
  // Clock and the shared data wire
  always #5 clk_sys = ~clk_sys;
  assign data_in = data_oe ? dut_data : host_data;
  host_cpu_bus_port i_dut (.i_clk_sys(clk_sys), .i_rst_b(rst_b), .i_bus_width_select(width),
    .i_bus_style_select(style), .i_host_data_lines(data_in), .o_host_data_lines(dut_data),
    .o_host_data_oe(data_oe), .i_host_address_lines(addr), .i_host_write_strobe_n(wr_n),
    .i_host_read_strobe_n(rd_n), .i_host_select_n(sel_n), .i_host_addr_latch_en(ale), .i_irq_src(irq_src),
    .i_irq_mask(irq_mask), .o_host_irq_n_oe(irq_oe), .i_reg_rdata({reg_addr, ~reg_addr}),
    .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd));
  host_bus_model i_host (.i_clk_sys(clk_sys), .i_style(style), .o_sel_n(sel_n), .o_wr_n(wr_n),
    .o_rd_n(rd_n), .o_ale(ale), .o_addr(addr), .o_data(host_data));
  // Compare, count and finish
  task automatic check(input string what, input logic [23:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [23:0] pop();
    return exp_q.size() ? exp_q.pop_front() : 24'hxx_xxxx;
  endfunction
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Note the expected result, then run the access
  task automatic run(input logic rd, cs);
    logic [7:0]  a, ea;
    logic [15:0] d;
    a = 8'($urandom);
    d = 16'($urandom);
    ea = width ? a : {a[7:1], 1'b0};
    if (!cs) exp_q.push_back(rd ? {8'h00, width ? 8'h00 : ea, ~ea} : {ea, width ? {8'h00, d[7:0]} : d});
    i_host.access(rd, cs, !rd && a[1], a, d);
  endtask
  // Compare each write pulse and each finished read
  always @(posedge clk_sys) begin
    if (reg_wr) check("write", {reg_addr, reg_wdata}, pop());
    if (reg_wr) check("rd flag on write", 24'(reg_rd), 24'h00_0000);
    if (oe_d && !data_oe) check("read", {8'h00, rd_seen}, pop());
    if (oe_d && !data_oe) check("rd flag", 24'(rd_flag), 24'h00_0001);
    if (data_oe) begin
      rd_seen = dut_data;
      rd_flag = reg_rd;
    end
    oe_d = data_oe;
  end
  // Random interrupt levels, checked one cycle later at the falling edge
  always @(posedge clk_sys) if (irq_on) {irq_src, irq_mask} <= #1 16'($urandom);
  always @(negedge clk_sys) begin
    if (irq_on) check("irq", 24'(irq_oe), 24'(irq_exp));
    irq_exp = |(irq_src & ~irq_mask);
  end
  // Hang guard
  initial begin
    #50_000;
    n_errors++;
    summarize();
  end
  // Reset, then each style and width with random accesses
  initial begin
    void'($urandom(32'hbec2_d537));
    repeat (3) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk_sys);
    irq_on = 1'b1;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys) #1 {style, width} = 2'(m);
      repeat (4) @(posedge clk_sys);
      repeat (10) run(1'($urandom), $urandom_range(3) == 0);
      $display("test style %0d width %0d done", style, width);
    end
    repeat (10) @(posedge clk_sys);
    check("left", 24'(exp_q.size()), 24'h00_0000);
    summarize();
  end
endmodule
